// ---- rtl/compare_pwm_params.svh ----
`ifndef COMPARE_PWM_PARAMS_SVH
`define COMPARE_PWM_PARAMS_SVH

// register byte addresses
`define OFS_CONTROL_ONE      12'h000
`define OFS_CONTROL_TWO      12'h004
`define OFS_DUTY_PRIMARY     12'h008
`define OFS_DUTY_SECONDARY   12'h00c
`define OFS_PERIOD           12'h010
`define OFS_TIMER_COUNT      12'h014
`define OFS_STATUS           12'h018

// control_one fields
`define MODE_LSB             0
`define MODE_MSB             2
`define PRESC_LSB            4
`define PRESC_MSB            5

// compare_control_two fields
`define SYNC_LSB             0
`define SYNC_MSB             4
`define FRAC_LSB             8
`define FRAC_MSB             9

// status fields
`define STAT_OUT_BIT         0
`define STAT_FRAC_LSB        1
`define STAT_FRAC_MSB        2

// reset values
`define RST_MODE             3'h0
`define RST_PRESC            2'h0
`define RST_SYNC             5'h00
`define RST_FRAC             2'h0
`define RST_WORD             16'h0000

// compare mode codes that select edge-aligned pwm
`define MODE_PWM_A           3'h6
`define MODE_PWM_B           3'h7

// source select codes
`define SYNC_NONE            5'h00
`define SYNC_TRIG_B          5'h1d
`define SYNC_TRIG_A          5'h1e
`define SYNC_SELF            5'h1f

// timing: instruction cycle is two oscillator (pclk) periods
`define ICY_DIV              2
// prescale ratios, minus one, for select codes 0..3
`define PRESC_R0             8'h00
`define PRESC_R1             8'h03
`define PRESC_R2             8'h07
`define PRESC_R3             8'hff

`endif

// ---- rtl/compare_pwm_pkg.sv ----
package compare_pwm_pkg;

   typedef struct packed {
      logic [2:0]  mode;
      logic [1:0]  presc_sel;
      logic [4:0]  sync_sel;
      logic [1:0]  frac;
      logic [1:0]  frac_act;
      logic [15:0] duty_primary;
      logic [15:0] duty_secondary;
      logic [15:0] period;
      logic [15:0] act_primary;
      logic [15:0] act_secondary;
      logic [15:0] timer;
      logic        icy_en;
      logic [7:0]  presc_cnt;
      logic        pin;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } pwm_state_t;

endpackage

// ---- rtl/compare_pwm_duty_sync.sv ----
`timescale 1ns/100ps
`include "compare_pwm_params.svh"
// Summary of operation
// - duty writes any time; active duty latches only at period end
// - duty primary, secondary and period all zero keep the pin low
// - in modes 110 and 111, secondary duty above period keeps the pin high
// - period is (period_value+1) times instruction cycle times prescale ratio
// - instruction cycle is two clock periods
// - duty resolution is log2 of instruction rate over pwm rate times prescale
// - five-bit source select; code 00000 means unsynchronised
// - code 11111 self, 11110 trigger input a, 11101 trigger input b
// - codes 00100..01010 channel sync outputs, 01011..01101 the timers
// - codes 10011..10111, 01110, 01111 channel events; 00001..00011 compares
// - duty fraction bits double-buffered only in modes 110 and 111
module compare_pwm_duty_sync (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [28:1] source_events,
   input  wire logic        external_trigger_in_a,
   input  wire logic        external_trigger_in_b,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   output logic             compare_output_pin,
   output logic             period_event
);

   compare_pwm_pkg::pwm_state_t state_reg;
   compare_pwm_pkg::pwm_state_t state_next;

   logic        pwm_mode;
   logic        tick;
   logic        match;
   logic        sync_hit;
   logic        period_end;
   logic [31:0] src_vec;
   logic [7:0]  presc_max;
   logic        period_event_reg;

   // all selectable sources by code; code 0 and unused slots are zero
   always_comb begin
      src_vec                     = 32'h0000_0000;
      src_vec[28:1]               = source_events;
      src_vec[`SYNC_TRIG_B]       = external_trigger_in_b;
      src_vec[`SYNC_TRIG_A]       = external_trigger_in_a;
      src_vec[`SYNC_SELF]         = tick & match;
   end

   assign pwm_mode = (state_reg.mode == `MODE_PWM_A) || (state_reg.mode == `MODE_PWM_B);

   always_comb begin
      unique case (state_reg.presc_sel)
         2'h0: presc_max = `PRESC_R0;
         2'h1: presc_max = `PRESC_R1;
         2'h2: presc_max = `PRESC_R2;
         2'h3: presc_max = `PRESC_R3;
      endcase
   end

   // timer advances once per instruction cycle per prescale count
   assign tick       = state_reg.icy_en && (state_reg.presc_cnt >= presc_max);
   assign match      = (state_reg.timer == state_reg.period);
   // code zero never restarts the timer
   assign sync_hit   = (state_reg.sync_sel != `SYNC_NONE) &&
                       src_vec[state_reg.sync_sel];
   assign period_end = (tick && match) || sync_hit;

   always_comb begin
      state_next         = state_reg;
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;

      // instruction clock enable: one pulse every second clock
      state_next.icy_en = ~state_reg.icy_en;
      if (state_reg.icy_en) begin
         // a smaller ratio written mid-count restarts the count, no long wrap
         if (state_reg.presc_cnt >= presc_max) begin
            state_next.presc_cnt = 8'h00;
         end else begin
            state_next.presc_cnt = state_reg.presc_cnt + 8'h01;
         end
      end

      // 16-bit time base; resolution follows from period_value width used
      if (sync_hit) begin
         state_next.timer = 16'h0000;
      end else if (tick) begin
         if (match) begin
            state_next.timer = 16'h0000;
         end else begin
            state_next.timer = state_reg.timer + 16'h0001;
         end
      end

      // double buffering of the duty values
      if (period_end) begin
         state_next.act_primary   = state_reg.duty_primary;
         state_next.act_secondary = state_reg.duty_secondary;
      end
      if (!pwm_mode) begin
         state_next.frac_act = state_reg.frac;
      end else if (period_end) begin
         state_next.frac_act = state_reg.frac;
      end

      // output pin
      if (!pwm_mode) begin
         state_next.pin = 1'b0;
      end else if (state_reg.act_secondary > state_reg.period) begin
         state_next.pin = 1'b1;
      end else if (state_reg.act_secondary == 16'h0000) begin
         state_next.pin = 1'b0;
      end else begin
         state_next.pin = (state_reg.timer < state_reg.act_secondary);
      end

      // apb slave: one wait state, answer in the second access cycle
      if (psel && penable && !state_reg.pready) begin
         state_next.pready = 1'b1;
         state_next.prdata = 32'h0000_0000;
         unique case (paddr)
            `OFS_CONTROL_ONE: begin
               if (pwrite) begin
                  state_next.mode      = pwdata[`MODE_MSB:`MODE_LSB];
                  state_next.presc_sel = pwdata[`PRESC_MSB:`PRESC_LSB];
               end else begin
                  state_next.prdata[`MODE_MSB:`MODE_LSB]   = state_reg.mode;
                  state_next.prdata[`PRESC_MSB:`PRESC_LSB] = state_reg.presc_sel;
               end
            end
            `OFS_CONTROL_TWO: begin
               if (pwrite) begin
                  state_next.sync_sel = pwdata[`SYNC_MSB:`SYNC_LSB];
                  state_next.frac     = pwdata[`FRAC_MSB:`FRAC_LSB];
               end else begin
                  state_next.prdata[`SYNC_MSB:`SYNC_LSB] = state_reg.sync_sel;
                  state_next.prdata[`FRAC_MSB:`FRAC_LSB] = state_reg.frac;
               end
            end
            `OFS_DUTY_PRIMARY: begin
               if (pwrite) begin
                  state_next.duty_primary = pwdata[15:0];
               end else begin
                  state_next.prdata[15:0] = state_reg.duty_primary;
               end
            end
            `OFS_DUTY_SECONDARY: begin
               if (pwrite) begin
                  state_next.duty_secondary = pwdata[15:0];
               end else begin
                  state_next.prdata[15:0] = state_reg.duty_secondary;
               end
            end
            `OFS_PERIOD: begin
               if (pwrite) begin
                  state_next.period = pwdata[15:0];
               end else begin
                  state_next.prdata[15:0] = state_reg.period;
               end
            end
            `OFS_TIMER_COUNT: begin
               if (!pwrite) begin
                  state_next.prdata[15:0] = state_reg.timer;
               end
            end
            `OFS_STATUS: begin
               if (!pwrite) begin
                  state_next.prdata[`STAT_OUT_BIT]                 = state_reg.pin;
                  state_next.prdata[`STAT_FRAC_MSB:`STAT_FRAC_LSB] = state_reg.frac_act;
               end
            end
            default: begin
               state_next.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.mode           <= `RST_MODE;
         state_reg.presc_sel      <= `RST_PRESC;
         state_reg.sync_sel       <= `RST_SYNC;
         state_reg.frac           <= `RST_FRAC;
         state_reg.frac_act       <= `RST_FRAC;
         state_reg.duty_primary   <= `RST_WORD;
         state_reg.duty_secondary <= `RST_WORD;
         state_reg.period         <= `RST_WORD;
         state_reg.act_primary    <= `RST_WORD;
         state_reg.act_secondary  <= `RST_WORD;
         state_reg.timer          <= `RST_WORD;
         state_reg.icy_en         <= 1'b0;
         state_reg.presc_cnt      <= 8'h00;
         state_reg.pin            <= 1'b0;
         state_reg.pready         <= 1'b0;
         state_reg.pslverr        <= 1'b0;
         state_reg.prdata         <= 32'h0000_0000;
         period_event_reg         <= 1'b0;
      end else begin
         state_reg                <= state_next;
         period_event_reg         <= period_end;
      end
   end

   assign pready             = state_reg.pready;
   assign pslverr            = state_reg.pslverr;
   assign prdata             = state_reg.prdata;
   assign compare_output_pin = state_reg.pin;
   assign period_event       = period_event_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_LATCH_AT_END: assert property (
      period_end |=> (state_reg.act_secondary == $past(state_reg.duty_secondary)) &&
                     (state_reg.act_primary == $past(state_reg.duty_primary)))
      else $error("duty not latched at period end");

   AST_HOLD_MID: assert property (
      !period_end |=> $stable(state_reg.act_secondary) && $stable(state_reg.act_primary))
      else $error("active duty changed mid period");

   AST_ZERO_DUTY: assert property (
      (state_reg.act_secondary == 16'h0000 && state_reg.act_primary == 16'h0000 &&
       state_reg.period == 16'h0000) |=> !compare_output_pin)
      else $error("zero duty did not hold pin low");

   AST_FULL_DUTY: assert property (
      (pwm_mode && state_reg.act_secondary > state_reg.period) |=> compare_output_pin)
      else $error("duty above period did not hold pin high");

   AST_WRAP: assert property (
      (tick && match && !sync_hit) |=> state_reg.timer == 16'h0000)
      else $error("timer did not wrap at period");

   AST_ICY_ALTERNATE: assert property (
      state_reg.icy_en |=> !state_reg.icy_en ##1 state_reg.icy_en)
      else $error("instruction enable not every second clock");

   AST_NO_SYNC: assert property (
      (state_reg.sync_sel == `SYNC_NONE && !tick) |=> $stable(state_reg.timer))
      else $error("unsynchronised timer moved without a tick");

   AST_TRIG_A: assert property (
      (state_reg.sync_sel == `SYNC_TRIG_A && external_trigger_in_a) |=>
         state_reg.timer == 16'h0000)
      else $error("trigger input a did not restart timer");

   AST_SOURCE_SYNC: assert property (
      (state_reg.sync_sel != `SYNC_NONE && src_vec[state_reg.sync_sel]) |=>
         state_reg.timer == 16'h0000 && period_event)
      else $error("selected source did not restart timer");

   AST_FRAC_BUFFER: assert property (
      (pwm_mode && !period_end) |=> $stable(state_reg.frac_act))
      else $error("fraction bits changed mid period in pwm mode");

   AST_FRAC_DIRECT: assert property (
      !pwm_mode |=> state_reg.frac_act == $past(state_reg.frac))
      else $error("fraction bits not direct outside pwm mode");

   AST_PERIOD_START: assert property (
      (pwm_mode && state_reg.timer == 16'h0000 && state_reg.act_secondary != 16'h0000)
         |=> compare_output_pin)
      else $error("pin not high at period start");

   AST_DUTY_REACHED: assert property (
      (pwm_mode && state_reg.act_secondary <= state_reg.period &&
       state_reg.timer >= state_reg.act_secondary) |=> !compare_output_pin)
      else $error("pin not low after duty reached");

   AST_APB_ANSWER: assert property (
      (psel && penable && !pready) |=> pready ##1 !pready)
      else $error("apb answer not one cycle after access start");

   AST_PIN_OFF_MODE: assert property (
      !pwm_mode |=> !compare_output_pin)
      else $error("pin not low outside pwm mode");

   AST_PRESC_RESTART: assert property (
      (state_reg.icy_en && state_reg.presc_cnt >= presc_max) |=> state_reg.presc_cnt == 8'h00)
      else $error("prescale count did not restart");

   AST_PRESC_HOLD: assert property (
      !state_reg.icy_en |=> $stable(state_reg.presc_cnt))
      else $error("prescale count moved between instruction cycles");

   AST_TIMER_STEP: assert property (
      (tick && !match && !sync_hit) |=> state_reg.timer == $past(state_reg.timer) + 16'h0001)
      else $error("timer did not advance by one on a tick");

   AST_TIMER_HOLD: assert property (
      (!tick && !sync_hit) |=> $stable(state_reg.timer))
      else $error("timer moved without a tick");

   AST_TRIG_B: assert property (
      (state_reg.sync_sel == `SYNC_TRIG_B && external_trigger_in_b) |=> state_reg.timer == 16'h0000)
      else $error("trigger input b did not restart timer");

   AST_SELF_ROLL: assert property (
      (state_reg.sync_sel == `SYNC_SELF && tick && match) |=> state_reg.timer == 16'h0000 && period_event)
      else $error("self select did not follow own rollover");

   AST_EVENT_SET: assert property (
      period_end |=> period_event)
      else $error("period event missing after period end");

   AST_EVENT_CLEAR: assert property (
      !period_end |=> !period_event)
      else $error("period event without period end");

   AST_FRAC_LATCH: assert property (
      (pwm_mode && period_end) |=> state_reg.frac_act == $past(state_reg.frac))
      else $error("fraction bits not latched at period end");

   AST_PERIOD_WRITE: assert property (
      (psel && penable && !pready && pwrite && paddr == `OFS_PERIOD) |=> state_reg.period == $past(pwdata[15:0]))
      else $error("period write did not land");

   AST_DUTY_WRITE: assert property (
      (psel && penable && !pready && pwrite && paddr == `OFS_DUTY_SECONDARY) |=>
         state_reg.duty_secondary == $past(pwdata[15:0]))
      else $error("secondary duty write did not land");

   AST_APB_ERR: assert property (
      (psel && penable && !pready && paddr > `OFS_STATUS) |=> pslverr && pready)
      else $error("unmapped address not answered with error");

   AST_ERR_WITH_READY: assert property (
      pslverr |-> pready)
      else $error("error response without ready");

   AST_TIMER_READ: assert property (
      (psel && penable && !pready && !pwrite && paddr == `OFS_TIMER_COUNT) |=>
         prdata == {16'h0000, $past(state_reg.timer)})
      else $error("timer count read wrong");

   AST_PRDATA_HOLD: assert property (
      !(psel && penable && !pready) |=> $stable(prdata))
      else $error("read data changed without a transfer");

   AST_IDLE_NO_WRITE: assert property (
      !(psel && penable && !pready) |=> $stable(state_reg.duty_secondary) && $stable(state_reg.period))
      else $error("register changed without a transfer");

endmodule

// ---- dv/source_event_model.sv ----
`timescale 1ns/100ps
// far-side timers, channels and trigger inputs: one-cycle pulse on the named line
module source_event_model (
   input  wire logic       pclk,
   input  wire logic       fire,
   input  wire logic [4:0] code,
   output logic [28:1]     source_events,
   output logic            external_trigger_in_a,
   output logic            external_trigger_in_b
);
   // code 11111 names this channel and owns no line; with it selected the channel triggers on its own rollover
   // capture, comparator and converter codes only ever give single trigger pulses
   always @(posedge pclk) begin
      source_events <= '0;
      external_trigger_in_a <= fire && code == 5'h1e;
      external_trigger_in_b <= fire && code == 5'h1d;
      if (fire && code inside {[5'h01:5'h1c]}) begin
         source_events[code] <= 1'b1;
      end
   end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`include "compare_pwm_params.svh"
`define CHK(g, e) begin \
   compares++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("Error at %0t: got %h expected %h", $time, g, e); \
   end \
end
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, fire, pready, pslverr, err, pin, pev, hit;
   logic        trig_a, trig_b;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  code;
   logic [28:1] events;
   int          failures, compares, cnt, hic, last_len, last_hi, k, o;
   int          ratio [4] = '{1, 4, 8, 256};

   compare_pwm_duty_sync i_compare_pwm_duty_sync (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .source_events(events),
      .external_trigger_in_a(trig_a), .external_trigger_in_b(trig_b), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .compare_output_pin(pin), .period_event(pev));
   source_event_model i_source_event_model (
      .pclk(pclk), .fire(fire), .code(code), .source_events(events),
      .external_trigger_in_a(trig_a), .external_trigger_in_b(trig_b));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // length and high time of each completed period, delimited by period_event
   always @(posedge pclk) begin
      if (pev === 1'b1) begin
         last_len <= cnt;
         last_hi <= hic;
         cnt <= 1;
         hic <= int'(pin === 1'b1);
      end else begin
         cnt <= cnt + 1;
         hic <= hic + int'(pin === 1'b1);
      end
   end

   task automatic report_and_stop();
      if (failures == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) failures++;
   endtask

   task automatic wait_ev(input int n);
      repeat (n) begin
         k = 0;
         do @(posedge pclk); while (pev !== 1'b1 && ++k < 5000);
         if (k >= 5000) failures++;
      end
      #1;
   endtask

   task automatic pulse(input logic [4:0] c);
      @(posedge pclk);
      fire <= 1'b1;
      code <= c;
      @(posedge pclk);
      fire <= 1'b0;
      hit = 1'b0;
      repeat (6) @(posedge pclk) if (pev === 1'b1) hit = 1'b1;
   endtask

   initial begin
      #2000000;
      failures++;
      report_and_stop();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      fire = 1'b0;
      code = '0;
      cnt = 0;
      hic = 0;
      void'($urandom(12));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_CONTROL_TWO, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 12'hffc, 32'h0);
      `CHK({err, rd}, 33'h100000000)
      // pwm mode with duties and period all zero
      apb(1'b1, `OFS_CONTROL_ONE, 32'h6);
      wait_ev(3);
      `CHK(last_hi, 0)
      `CHK(last_len, 2)
      // period only grows from here so the timer never runs past it
      apb(1'b1, `OFS_PERIOD, 32'h3);
      apb(1'b1, `OFS_DUTY_SECONDARY, 32'h2);
      for (int p = 0; p < 4; p++) begin
         // odd passes use pwm mode 111, even ones 110
         apb(1'b1, `OFS_CONTROL_ONE, (32'(p) << 4) | 32'h6 | 32'(p % 2));
         wait_ev(3);
         `CHK(last_len, 8 * ratio[p])
         `CHK(last_hi, 4 * ratio[p])
      end
      apb(1'b1, `OFS_CONTROL_ONE, 32'h6);
      apb(1'b1, `OFS_PERIOD, 32'hf);
      apb(1'b1, `OFS_DUTY_SECONDARY, 32'h4);
      wait_ev(3);
      apb(1'b1, `OFS_DUTY_SECONDARY, 32'ha);
      wait_ev(1);
      `CHK(last_hi, 8)
      wait_ev(1);
      `CHK(last_hi, 20)
      apb(1'b1, `OFS_DUTY_SECONDARY, 32'h10);
      wait_ev(3);
      `CHK(last_hi, 32)
      // fraction bits: direct outside pwm, buffered inside it
      apb(1'b1, `OFS_CONTROL_ONE, 32'h0);
      apb(1'b1, `OFS_CONTROL_TWO, 32'h300);
      apb(1'b0, `OFS_STATUS, 32'h0);
      `CHK(rd[2:1], 2'h3)
      apb(1'b1, `OFS_CONTROL_ONE, 32'h6);
      apb(1'b1, `OFS_PERIOD, 32'hff);
      wait_ev(1);
      apb(1'b1, `OFS_CONTROL_TWO, 32'h100);
      apb(1'b0, `OFS_STATUS, 32'h0);
      `CHK(rd[2:1], 2'h3)
      wait_ev(1);
      apb(1'b0, `OFS_STATUS, 32'h0);
      `CHK(rd[2:1], 2'h1)
      // every source code below 11111: a foreign line is ignored; for 00001..11110 the selected one restarts
      wait_ev(1);
      // long period so no own rollover falls inside a pulse window
      apb(1'b1, `OFS_PERIOD, 32'hffff);
      // code 11111 would make the channel its own trigger, so it is left out
      for (int c = 0; c < 31; c++) begin
         apb(1'b1, `OFS_CONTROL_TWO, 32'(c));
         o = 1 + int'($urandom % 30);
         if (o == c) o = o % 30 + 1;
         pulse(5'(o));
         `CHK(hit, 1'b0)
         if (c >= 1 && c <= 30) begin
            pulse(5'(c));
            `CHK(hit, 1'b1)
         end
      end
      report_and_stop();
   end
endmodule
